// file: include/gpt_pkg.sv
/*
 * package of the gated period timer: register map, field layout,
 * reset values, mode codes and timing constants.
 * assumes: byte addressed avalon-mm slave with 32-bit data.
 */
package gpt_pkg;

   // --------------------------------------------------------------
   // register byte offsets
   // --------------------------------------------------------------
   localparam logic [4:0] REG_CTRL   = 5'h00;
   localparam logic [4:0] REG_PERIOD = 5'h04;
   localparam logic [4:0] REG_COUNT  = 5'h08;
   localparam logic [4:0] REG_DUTY   = 5'h0c;
   localparam logic [4:0] REG_STATUS = 5'h10;
   localparam logic [4:0] REG_MASK   = 5'h14;

   // --------------------------------------------------------------
   // field positions and reset values
   // --------------------------------------------------------------
   localparam int CTRL_W        = 7;
   localparam int STAT_W        = 2;
   localparam int STAT_MATCH    = 0;
   localparam int STAT_GATESTOP = 1;
   localparam logic [6:0] CTRL_RST   = 7'h00;
   localparam logic [7:0] PERIOD_RST = 8'hff;
   localparam logic [7:0] DUTY_RST   = 8'h00;
   localparam logic [7:0] COUNT_RST  = 8'h00;
   localparam logic [1:0] STAT_RST   = 2'h0;

   // --------------------------------------------------------------
   // timing: system clock and the divided timer clock
   // --------------------------------------------------------------
   localparam int SYS_PERIOD_NS  = 5;
   localparam int TCLK_PERIOD_NS = 20;
   localparam int TCLK_DIV       = (TCLK_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam logic [1:0] TDIV_LAST = 2'(TCLK_DIV - 1);

   // --------------------------------------------------------------
   // types
   // --------------------------------------------------------------
   typedef enum logic [4:0] {
      MODE_SW_GATE = 5'b00000,
      MODE_GATE_HI = 5'b00001,
      MODE_GATE_LO = 5'b00010
   } gpt_mode_t;

   typedef struct packed {
      logic [4:0] mode;
      logic       inst_clk;
      logic       run;
   } gpt_ctrl_t;

endpackage

// file: rtl/gpt_top.sv
/*
 * gated period timer: 8-bit counter with software and hardware gating,
 * avalon-mm register slave, sticky events with mask, pwm compare output.
 * assumes: one system clock, gate input asynchronous to it.
 */
`timescale 1ns/1ps

// Overview of operation
// - divided timer clock: run bit and gate take effect two timer clocks late
// - instruction clock: gate delayed one period, run acts in next period
// - software gate: count on every timer clock while run set, else hold
// - count equal to period clears to zero on next timer clock
// - hardware gate modes also stop counting while gate inactive
// - mode 00001 runs on gate high, mode 00010 runs on gate low
// - gating stops counter so pwm period and high time stretch
module gpt_top
   import gpt_pkg::*;
(
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_RST_N,
   input  wire logic [4:0]  I_AVS_ADDRESS,
   input  wire logic        I_AVS_READ,
   input  wire logic        I_AVS_WRITE,
   input  wire logic [31:0] I_AVS_WRITEDATA,
   input  wire logic        I_EXT_GATE_RESET_IN,
   output logic      [31:0] O_AVS_READDATA,
   output logic             O_AVS_WAITREQUEST,
   output logic             O_IRQ,
   output logic             O_POSTSCALED_MATCH,
   output logic             O_PWM
);

   // --------------------------------------------------------------
   // reset release
   // --------------------------------------------------------------
   logic rst_m;
   logic rst_n;

   always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rst_m <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_m <= 1'b1;
         rst_n <= rst_m;
      end
   end

   // --------------------------------------------------------------
   // registers and internal state
   // --------------------------------------------------------------
   gpt_ctrl_t         ctrl;
   logic [7:0]        period_value;
   logic [7:0]        duty;
   logic [7:0]        count_value;
   logic [STAT_W-1:0] status;
   logic [STAT_W-1:0] mask;
   logic [1:0]        tdiv;
   logic              tick;
   logic [1:0]        run_p;
   logic [1:0]        gate_p;
   logic              gate_m;
   logic              gate_s;
   logic              run_eff;
   logic              gate_eff;
   logic              gate_ok;
   logic              gate_ok_q;
   logic              advance;
   logic              wrap;
   logic              ev_gatestop;
   logic              acc;
   logic              wr_en;
   logic [31:0]       next_readdata;

   // --------------------------------------------------------------
   // avalon-mm slave, one wait state per access
   // --------------------------------------------------------------
   assign acc   = (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST;
   // write lands at the completing edge, while waitrequest is low
   assign wr_en = I_AVS_WRITE && !O_AVS_WAITREQUEST;

   always_comb begin
      next_readdata = 32'h0000_0000;
      unique case (I_AVS_ADDRESS)
         REG_CTRL:   next_readdata = {25'h000_0000, ctrl};
         REG_PERIOD: next_readdata = {24'h00_0000, period_value};
         REG_COUNT:  next_readdata = {24'h00_0000, count_value};
         REG_DUTY:   next_readdata = {24'h00_0000, duty};
         REG_STATUS: next_readdata = {30'h0000_0000, status};
         REG_MASK:   next_readdata = {30'h0000_0000, mask};
         default:    next_readdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_AVS_WAITREQUEST <= 1'b1;
         O_AVS_READDATA    <= 32'h0000_0000;
      end else begin
         O_AVS_WAITREQUEST <= !acc;
         if (acc && I_AVS_READ) begin
            O_AVS_READDATA <= next_readdata;
         end
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ctrl         <= CTRL_RST;
         period_value <= PERIOD_RST;
         duty         <= DUTY_RST;
         mask         <= STAT_RST;
      end else if (wr_en) begin
         unique case (I_AVS_ADDRESS)
            REG_CTRL:   ctrl         <= I_AVS_WRITEDATA[CTRL_W-1:0];
            REG_PERIOD: period_value <= I_AVS_WRITEDATA[7:0];
            REG_DUTY:   duty         <= I_AVS_WRITEDATA[7:0];
            REG_MASK:   mask         <= I_AVS_WRITEDATA[STAT_W-1:0];
            default:    ;
         endcase
      end
   end

   // --------------------------------------------------------------
   // timer clock enable
   // --------------------------------------------------------------
   assign tick = ctrl.inst_clk || (tdiv == TDIV_LAST);

   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         tdiv <= 2'h0;
      end else if (tick) begin
         tdiv <= 2'h0;
      end else begin
         tdiv <= tdiv + 2'h1;
      end
   end

   // --------------------------------------------------------------
   // synchronisation of run bit and gate input
   // --------------------------------------------------------------
   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         gate_m <= 1'b0;
         gate_s <= 1'b0;
      end else begin
         gate_m <= I_EXT_GATE_RESET_IN;
         gate_s <= gate_m;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         run_p  <= 2'h0;
         gate_p <= 2'h0;
      end else if (tick) begin
         run_p  <= {run_p[0], ctrl.run};
         gate_p <= {gate_p[0], gate_s};
      end
   end

   assign run_eff  = ctrl.inst_clk ? run_p[0] : run_p[1];
   assign gate_eff = ctrl.inst_clk ? gate_p[0] : gate_p[1];

   // --------------------------------------------------------------
   // gating and counter
   // --------------------------------------------------------------
   // gate polarity per mode
   always_comb begin
      unique case (ctrl.mode)
         MODE_GATE_HI: gate_ok = gate_eff;
         MODE_GATE_LO: gate_ok = !gate_eff;
         default:      gate_ok = 1'b1;
      endcase
   end

   assign advance     = tick && run_eff && gate_ok;
   assign wrap        = advance && (count_value == period_value);
   assign ev_gatestop = gate_ok_q && !gate_ok && run_eff;

   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         count_value <= COUNT_RST;
      end else if (wrap) begin
         count_value <= 8'h00;
      end else if (advance) begin
         count_value <= count_value + 8'h01;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         gate_ok_q          <= 1'b1;
         O_POSTSCALED_MATCH <= 1'b0;
      end else begin
         gate_ok_q          <= gate_ok;
         O_POSTSCALED_MATCH <= wrap;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_PWM <= 1'b0;
      end else begin
         O_PWM <= count_value < duty;
      end
   end

   // --------------------------------------------------------------
   // events and interrupt
   // --------------------------------------------------------------
   // set wins over write-one-to-clear
   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         status <= STAT_RST;
      end else begin
         if (wr_en && I_AVS_ADDRESS == REG_STATUS) begin
            status <= status & ~I_AVS_WRITEDATA[STAT_W-1:0]
                      | {ev_gatestop, wrap};
         end else begin
            status <= status | {ev_gatestop, wrap};
         end
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_IRQ <= 1'b0;
      end else begin
         O_IRQ <= |(status & mask);
      end
   end

   // --------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------
   a_run_sync_two: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (!ctrl.inst_clk && $past(!ctrl.inst_clk) && $rose(run_eff))
      |-> $past(ctrl.run) && $past(ctrl.run, 2))
      else $error("run took effect too early");

   a_run_next_period: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (ctrl.inst_clk && $past(ctrl.inst_clk)) |-> run_eff == $past(ctrl.run))
      else $error("run not applied in next period");

   a_count_hold: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      !run_eff |=> $stable(count_value))
      else $error("count moved while stopped");

   a_count_step: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (advance && count_value != period_value)
      |=> count_value == $past(count_value) + 8'h01)
      else $error("count did not step by one");

   a_wrap_zero: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (tick && run_eff && gate_ok && count_value == period_value)
      |=> count_value == 8'h00 && O_POSTSCALED_MATCH == 1'b1)
      else $error("count did not clear after match");

   a_gate_hi_stop: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (ctrl.mode == MODE_GATE_HI && !gate_eff) |=> $stable(count_value))
      else $error("low gate did not stop count");

   a_gate_lo_stop: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (ctrl.mode == MODE_GATE_LO && gate_eff && run_eff && tick)
      |=> $stable(count_value))
      else $error("inverted gate polarity wrong");

   a_pwm_stretch: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (!advance && $past(!advance) && $stable(duty) && $past(rst_n))
      |=> $stable(O_PWM))
      else $error("pwm changed while timer gated");

endmodule

// file: tb/gpt_gate_src.sv
/* model of the external gate source in front of the timer.
   assumes: driven from the system clock of the bench. */
`timescale 1ns/1ps
module gpt_gate_src #(
   parameter int MIN_HOLD = 12
) (
   input  wire logic i_clk,
   input  wire logic i_level,
   output logic      o_gate
);
   int held;
   initial begin
      o_gate = 1'b0;
      held   = MIN_HOLD;
   end
   always @(posedge i_clk) begin
      if (i_level != o_gate && held >= MIN_HOLD) begin
         o_gate <= i_level;
         held   <= 0;
      end else if (held < MIN_HOLD) begin
         held <= held + 1;
      end
   end
endmodule

// file: tb/gated_period_timer_tb.sv
/* self-checking bench of the gated period timer; reads checked from a queue.
   assumes: gpt_pkg, gpt_top and gpt_gate_src compiled before. */
`timescale 1ns/1ps
module gated_period_timer_tb;
   import gpt_pkg::*;
   logic        clk, rst_n, rd, wr, gate_req, gate, wait_rq, irq, match, pwm;
   logic [4:0]  addr;
   logic [31:0] wdata, rdata, last_rd;
   logic [31:0] expq[$];
   logic [7:0]  exp_cnt;
   int          fail_count, n_tests, cyc, npulse, p0, t_on, t_off, d, dl;
   logic [4:0]  radr [7] = '{REG_CTRL, REG_PERIOD, REG_COUNT, REG_DUTY, REG_STATUS,
                            REG_MASK, 5'h18};
   logic [31:0] rexp [7] = '{{25'h0, CTRL_RST}, {24'h0, PERIOD_RST}, {24'h0, COUNT_RST},
                            {24'h0, DUTY_RST}, {30'h0, STAT_RST}, 32'h0, 32'h0};
   gpt_top uut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
      .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_EXT_GATE_RESET_IN(gate),
      .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wait_rq), .O_IRQ(irq),
      .O_POSTSCALED_MATCH(match), .O_PWM(pwm));
   gpt_gate_src #(.MIN_HOLD(12)) src (.i_clk(clk), .i_level(gate_req), .o_gate(gate));
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] dat);
      @(posedge clk);
      addr  <= a;
      wdata <= dat;
      wr    <= w;
      rd    <= !w;
      do begin
         @(posedge clk);
      end while (wait_rq !== 1'b0);
      last_rd = rdata;
      d = cyc;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic rdq(input logic [4:0] a, input logic [31:0] exp);
      expq.push_back(exp);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // --------------------------------------------------------------
   // clock, counters, read monitor, watchdog
   // --------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   always @(posedge clk) if (match === 1'b1) npulse <= npulse + 1;
   always @(posedge clk) begin
      if (rd && wait_rq === 1'b0 && expq.size() > 0) begin
         check("readdata", rdata, expq.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      complete_run();
   end
   // --------------------------------------------------------------
   // tests
   // --------------------------------------------------------------
   initial begin
      rst_n = 1'b0; rd = 1'b0; wr = 1'b0; addr = 5'h00; wdata = 32'h0; gate_req = 1'b0;
      fail_count = 0; n_tests = 0; cyc = 0; npulse = 0;
      void'($urandom(88358));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      bus(1'b1, REG_COUNT, 32'h33);
      bus(1'b1, 5'h18, 32'hff);
      foreach (radr[i]) rdq(radr[i], rexp[i]);
      $display("test reset values done");
      // count while run, hold when clear
      bus(1'b1, REG_PERIOD, {24'($urandom()), 8'h05});
      p0 = npulse;
      bus(1'b1, REG_CTRL, 32'h03);
      t_on = d;
      repeat (20 + $urandom_range(40)) @(posedge clk);
      bus(1'b1, REG_CTRL, 32'h02);
      t_off = d;
      exp_cnt = 8'((t_off - t_on) % 6);
      rdq(REG_COUNT, {24'h0, exp_cnt});
      repeat (10) @(posedge clk);
      rdq(REG_COUNT, {24'h0, exp_cnt});
      check("match pulses", npulse - p0, (t_off - t_on) / 6);
      rdq(REG_STATUS, 32'h1);
      check("irq masked", {31'h0, irq}, 32'h0);
      bus(1'b1, REG_MASK, 32'h1);
      repeat (3) @(posedge clk);
      check("irq set", {31'h0, irq}, 32'h1);
      bus(1'b1, REG_STATUS, 32'h1);
      repeat (3) @(posedge clk);
      check("irq cleared", {31'h0, irq}, 32'h0);
      rdq(REG_STATUS, 32'h0);
      $display("test count and irq done");
      for (int m = 1; m < 3; m++) begin
         // stop run under the old gating first: run clears one period late
         bus(1'b1, REG_CTRL, {25'h0, 5'(m - 1), 2'b10});
         gate_req <= (m == 2);
         repeat (20) @(posedge clk);
         bus(1'b1, REG_CTRL, {25'h0, 5'(m), 2'b11});
         repeat (30) @(posedge clk);
         rdq(REG_COUNT, {24'h0, exp_cnt});
      end
      $display("test gate hold done");
      // divided clock start delay and rate
      bus(1'b1, REG_CTRL, 32'h0a);
      bus(1'b1, REG_PERIOD, 32'hff);
      bus(1'b1, REG_CTRL, 32'h01);
      t_on = d;
      rdq(REG_COUNT, {24'h0, exp_cnt});
      repeat (60) @(posedge clk);
      bus(1'b1, REG_CTRL, 32'h00);
      t_off = d;
      bus(1'b0, REG_COUNT, 32'h0);
      dl = int'(last_rd[7:0] - exp_cnt);
      check("tick rate", 32'(dl >= (t_off - t_on) / 4 - 4 && dl <= (t_off - t_on) / 4 + 2),
         32'h1);
      $display("test divided clock done");
      bus(1'b1, REG_MASK, 32'h2);
      for (int m = 1; m < 3; m++) begin
         bus(1'b1, REG_CTRL, 32'h02);
         gate_req <= (m == 2);
         repeat (20) @(posedge clk);
         bus(1'b1, REG_STATUS, 32'h3);
         bus(1'b1, REG_CTRL, {25'h0, 5'(m), 2'b11});
         gate_req <= (m == 1);
         repeat (40) @(posedge clk);
         rdq(REG_STATUS, 32'h0);
         gate_req <= (m == 2);
         repeat (20) @(posedge clk);
         check("irq gate stop", {31'h0, irq}, 32'h1);
         rdq(REG_STATUS, 32'h2);
      end
      $display("test gate run and stop done");
      // pwm high time stretched while gated
      bus(1'b0, REG_COUNT, 32'h0);
      bus(1'b1, REG_DUTY, {24'h0, last_rd[7:0] + 8'h01});
      repeat (2) @(posedge clk);
      repeat (6) begin
         repeat (4) @(posedge clk);
         check("pwm held", {31'h0, pwm}, 32'h1);
      end
      gate_req <= 1'b0;
      repeat (12) @(posedge clk);
      check("pwm released", {31'h0, pwm}, 32'h0);
      $display("test pwm stretch done");
      repeat (3) @(posedge clk);
      check("reads left", expq.size(), 32'h0);
      complete_run();
   end
endmodule
